/* File: rtl/adcsp_pkg.sv */
package adcsp_pkg;

  // Clock and timing
  localparam int CLK_MHZ = 200;
  localparam int READY_PULSE_NS = 20;
  localparam int PULSE_CYC = (READY_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PCNT_W = 3;
  localparam int TIMEOUT_US = 100;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;

  // Result format
  localparam int RES_W = 24;
  localparam int RAW_W = 26;
  localparam logic [4:0] RES_BITS = 5'h18;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic signed [RAW_W-1:0] RAW_POS_LIM = 26'sh07fffff;
  localparam logic signed [RAW_W-1:0] RAW_NEG_LIM = 26'sh3800000;
  localparam logic [RES_W-1:0] RES_MAX = 24'h7fffff;
  localparam logic [RES_W-1:0] RES_MIN = 24'h800000;

  // Register map
  localparam int NUM_REGS = 11;
  localparam logic [3:0] IDX_BURNOUT_SOURCE_CONTROL = 4'h0;
  localparam logic [3:0] IDX_INPUT_BIAS_ENABLE = 4'h1;
  localparam logic [3:0] IDX_MONITOR_SELECT_CLOCK_STATUS = 4'h2;
  localparam logic [3:0] IDX_GAIN_RATE_CONFIG = 4'h3;
  localparam logic [3:0] IDX_OFFSET_COEFF_LOW = 4'h4;
  localparam logic [3:0] IDX_OFFSET_COEFF_MID = 4'h5;
  localparam logic [3:0] IDX_OFFSET_COEFF_HIGH = 4'h6;
  localparam logic [3:0] IDX_FULLSCALE_COEFF_LOW = 4'h7;
  localparam logic [3:0] IDX_FULLSCALE_COEFF_MID = 4'h8;
  localparam logic [3:0] IDX_FULLSCALE_COEFF_HIGH = 4'h9;
  localparam logic [3:0] IDX_PART_CODE_AND_PIN_MODE = 4'ha;
  localparam logic [7:0] FSC_RST = 8'h00;
  localparam logic [7:0] REG_RST [NUM_REGS] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, FSC_RST, FSC_RST, FSC_RST, 8'h00};
  localparam logic [7:0] REG_WMASK [NUM_REGS] = '{8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h08};
  localparam int OSC_FLAG_BIT = 7;
  localparam int SHARED_MODE_BIT = 3;

  // Command opcodes
  localparam logic [7:0] CMD_WAKE = 8'h00;
  localparam logic [7:0] CMD_READ = 8'h12;
  localparam logic [7:0] CMD_CONT = 8'h14;
  localparam logic [7:0] CMD_STOP = 8'h16;
  localparam logic [3:0] CMD_REGISTER_READ_CMD_HI = 4'h2;
  localparam logic [3:0] CMD_WREG_HI = 4'h4;
  localparam logic [7:0] CMD_NOP = 8'hff;

  typedef enum {ST_CMD, ST_RCNT, ST_WCNT, ST_WDATA} adcsp_state_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
    logic start;
    logic sleep;
    logic ext_osc;
  } adcsp_pins_t;

endpackage

/* File: rtl/adcsp_serial_port.sv */
`timescale 1ns/100ps
// Functional notes
// - Chip select high: output off, port reset
// - Ready pin falls and conversions run regardless of chip select
// - Timeout exists; host writes whole bytes
// - Sample input on fall, drive on rise
// - Input decoded as commands during readout
// - Result stored, ready low, shifter loaded in continuous mode
// - Ready returns high on next clock fall
// - Still low at new result: pulse high
// - Mode clear: shared pin is data, MSB first
// - Mode set: shared pin falls per result
// - Mode set: shared pin high after full readout
// - Mode bit leaves ready pin unchanged
// - Chip select resets port; RST resets all
// - Sleep accepts only five commands
// - Sleep read returns last stored result
// - Result saturates to 24-bit limits
module adcsp_serial_port
  import adcsp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter logic [3:0] PART_CODE = 4'h5  // Arbitrary value
) (
  // System
  input wire logic CLK,
  input wire logic RST,
  // Serial pins
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DIN,
  output logic DOUT,
  output logic DOUT_OE,
  // Dedicated ready pin
  output logic CONV_READY_N,
  // Power and oscillator pins
  input wire logic START,
  input wire logic SLEEP,
  input wire logic EXT_OSC,
  // Converter core, same clock
  input wire logic RES_VALID,
  input wire logic signed [RAW_W-1:0] RES_RAW,
  output logic WAKE_REQ
);

  ////////////////////////////////////////////////////////////////////////////
  adcsp_pins_t pin_m;
  adcsp_pins_t pin_s;
  logic sclk_d;
  logic active;
  logic sclk_fall;
  logic sclk_rise;
  logic sleeping;

  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_m <= '{cs_n: 1'b1, default: 1'b0};
      pin_s <= '{cs_n: 1'b1, default: 1'b0};
      sclk_d <= 1'b0;
    end else begin
      pin_m <= '{CS_N, SCLK, DIN, START, SLEEP, EXT_OSC};
      pin_s <= pin_m;
      sclk_d <= pin_s.sclk;
    end
  end

  assign active = ~pin_s.cs_n;
  assign sclk_fall = sclk_d & ~pin_s.sclk;
  assign sclk_rise = ~sclk_d & pin_s.sclk;
  assign sleeping = ~pin_s.start | pin_s.sleep;
  assign DOUT_OE = active;

  ////////////////////////////////////////////////////////////////////////////
  adcsp_state_t state;
  logic [6:0] rx;
  logic [2:0] bit_cnt;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [31:0] to_cnt;
  logic to_hit;

  assign rx_byte = {rx, pin_s.din};
  assign byte_done = active & sclk_fall & (bit_cnt == 3'h7);
  assign to_hit = (to_cnt == TIMEOUT_CYCLES - 1);

  always_ff @(posedge CLK) begin
    if (RST || !active || to_hit) begin
      rx <= 7'h00;
      bit_cnt <= 3'h0;
    end else if (sclk_fall) begin
      rx <= rx_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Counts only while a command is half received, so an idle port never times out
  always_ff @(posedge CLK) begin
    if (RST || !active || sclk_fall || sclk_rise || (bit_cnt == 3'h0 && state == ST_CMD)) begin
      to_cnt <= 32'h0;
    end else begin
      to_cnt <= to_cnt + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] regs [NUM_REGS];
  logic [3:0] addr;
  logic [3:0] wr_left;
  logic [3:0] register_read_cmd_left;
  logic cont_mode;
  logic shared_mode;
  logic allowed;
  logic cmd_ok;
  logic cmd_load_res;
  logic register_read_cmd_load;
  logic reg_we;

  function automatic logic sleep_ok(input logic [7:0] b);
    return b == CMD_READ || b == CMD_CONT || b == CMD_STOP || b == CMD_WAKE || b == CMD_NOP;
  endfunction

  function automatic logic [7:0] reg_read(input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == IDX_MONITOR_SELECT_CLOCK_STATUS) begin
      v = {pin_s.ext_osc, regs[a][OSC_FLAG_BIT-1:0]};
    end else if (a == IDX_PART_CODE_AND_PIN_MODE) begin
      v = {PART_CODE, regs[a][3:0]};
    end else if (a < 4'(NUM_REGS)) begin
      v = regs[a];
    end
    return v;
  endfunction

  assign shared_mode = regs[IDX_PART_CODE_AND_PIN_MODE][SHARED_MODE_BIT];
  assign allowed = !sleeping || sleep_ok(rx_byte);
  assign cmd_ok = byte_done && state == ST_CMD && allowed;
  assign cmd_load_res = cmd_ok && rx_byte == CMD_READ;
  assign register_read_cmd_load = byte_done && (state == ST_RCNT ||
    (state == ST_CMD && register_read_cmd_left != 4'h0 && rx_byte == CMD_NOP));
  assign reg_we = byte_done && state == ST_WDATA && addr < 4'(NUM_REGS);

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ST_CMD;
      addr <= 4'h0;
      wr_left <= 4'h0;
      register_read_cmd_left <= 4'h0;
      cont_mode <= 1'b1;
      WAKE_REQ <= 1'b0;
    end else begin
      WAKE_REQ <= cmd_ok && rx_byte == CMD_WAKE;
      if (!active || to_hit) begin
        state <= ST_CMD;
        register_read_cmd_left <= 4'h0;
      end else if (byte_done) begin
        case (state)
          ST_CMD: begin
            if (register_read_cmd_left != 4'h0 && rx_byte == CMD_NOP) begin
              addr <= addr + 4'h1;
              register_read_cmd_left <= register_read_cmd_left - 4'h1;
            end else begin
              register_read_cmd_left <= 4'h0;
              if (allowed) begin
                if (rx_byte == CMD_CONT) begin
                  cont_mode <= 1'b1;
                end
                if (rx_byte == CMD_STOP) begin
                  cont_mode <= 1'b0;
                end
                if (rx_byte[7:4] == CMD_REGISTER_READ_CMD_HI) begin
                  state <= ST_RCNT;
                  addr <= rx_byte[3:0];
                end
                if (rx_byte[7:4] == CMD_WREG_HI) begin
                  state <= ST_WCNT;
                  addr <= rx_byte[3:0];
                end
              end
            end
          end
          ST_RCNT: begin
            register_read_cmd_left <= rx_byte[3:0];
            addr <= addr + 4'h1;
            state <= ST_CMD;
          end
          ST_WCNT: begin
            wr_left <= rx_byte[3:0];
            state <= ST_WDATA;
          end
          ST_WDATA: begin
            addr <= addr + 4'h1;
            wr_left <= wr_left - 4'h1;
            if (wr_left == 4'h0) begin
              state <= ST_CMD;
            end
          end
          default: begin
            state <= ST_CMD;
          end
        endcase
      end
    end
  end

  // Registers survive a chip-select reset; only RST restores them
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RST[i];
      end
    end else if (reg_we) begin
      regs[addr] <= (regs[addr] & ~REG_WMASK[addr]) | (rx_byte & REG_WMASK[addr]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [RES_W-1:0] res_sat;
  logic [RES_W-1:0] result_buf;
  logic res_load;
  logic conv_ready_n_pend;
  logic [PCNT_W-1:0] conv_ready_n_cnt;

  function automatic logic [RES_W-1:0] sat24(input logic signed [RAW_W-1:0] r);
    logic [RES_W-1:0] v;
    v = r[RES_W-1:0];
    if (r > RAW_POS_LIM) begin
      v = RES_MAX;
    end else if (r < RAW_NEG_LIM) begin
      v = RES_MIN;
    end
    return v;
  endfunction

  assign res_sat = sat24(RES_RAW);
  // A result landing mid-byte or with the clock high would corrupt a transfer in flight
  assign res_load = RES_VALID && cont_mode &&
    (!active || (!pin_s.sclk && bit_cnt == 3'h0));

  always_ff @(posedge CLK) begin
    if (RST) begin
      result_buf <= '0;
    end else if (RES_VALID) begin
      result_buf <= res_sat;
    end
  end

  // Ready pin logic never looks at the mode bit; chip select gates only the release on a clock fall
  always_ff @(posedge CLK) begin
    if (RST) begin
      CONV_READY_N <= 1'b1;
      conv_ready_n_pend <= 1'b0;
      conv_ready_n_cnt <= '0;
    end else if (RES_VALID) begin
      if (!CONV_READY_N) begin
        CONV_READY_N <= 1'b1;
        conv_ready_n_pend <= 1'b1;
        conv_ready_n_cnt <= PCNT_W'(PULSE_CYC - 1);
      end else begin
        CONV_READY_N <= 1'b0;
      end
    end else if (conv_ready_n_pend) begin
      if (conv_ready_n_cnt == '0) begin
        CONV_READY_N <= 1'b0;
        conv_ready_n_pend <= 1'b0;
      end else begin
        conv_ready_n_cnt <= conv_ready_n_cnt - 1'b1;
      end
    end else if (active && sclk_fall && !CONV_READY_N) begin
      CONV_READY_N <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [RES_W-1:0] tx;
  logic [4:0] tx_bits;
  logic dout_pend;
  logic [PCNT_W-1:0] dout_cnt;

  always_ff @(posedge CLK) begin
    if (RST) begin
      tx <= '0;
      tx_bits <= 5'h00;
    end else if (cmd_load_res) begin
      tx <= result_buf;
      tx_bits <= RES_BITS;
    end else if (register_read_cmd_load) begin
      tx <= {reg_read(addr), 16'h0000};
      tx_bits <= BYTE_BITS;
    end else if (res_load) begin
      tx <= res_sat;
      tx_bits <= RES_BITS;
    end else if (active && sclk_rise && tx_bits != 5'h00) begin
      tx <= {tx[RES_W-2:0], 1'b0};
      tx_bits <= tx_bits - 5'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      DOUT <= 1'b1;
      dout_pend <= 1'b0;
      dout_cnt <= '0;
    end else if (RES_VALID && shared_mode) begin
      DOUT <= !DOUT;
      dout_pend <= !DOUT;
      dout_cnt <= PCNT_W'(PULSE_CYC - 1);
    end else if (dout_pend) begin
      if (dout_cnt == '0) begin
        DOUT <= 1'b0;
        dout_pend <= 1'b0;
      end else begin
        dout_cnt <= dout_cnt - 1'b1;
      end
    end else if (active && sclk_rise) begin
      if (tx_bits != 5'h00) begin
        DOUT <= tx[RES_W-1];
      end else if (shared_mode) begin
        DOUT <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_ready_pulse;
    CONV_READY_N [*4] ##1 !CONV_READY_N;
  endsequence

  property p_oe_off;
    $rose(CS_N) |-> ##[1:3] !DOUT_OE;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enabled with chip select high");

  property p_ready_release;
    active && sclk_fall && !CONV_READY_N && !RES_VALID && !conv_ready_n_pend |=> CONV_READY_N;
  endproperty
  a_ready_release: assert property (p_ready_release) else $error("ready not released");

  // Result spacing of four or more cycles keeps the pulse from being cut short
  property p_ready_repulse;
    RES_VALID && !CONV_READY_N |=> s_ready_pulse;
  endproperty
  a_ready_repulse: assert property (p_ready_repulse) else $error("no ready pulse");

  property p_result_store;
    RES_VALID && CONV_READY_N && !conv_ready_n_pend |=> !CONV_READY_N && result_buf == $past(res_sat);
  endproperty
  a_result_store: assert property (p_result_store) else $error("result not stored");

  property p_msb_first;
    !shared_mode && active && sclk_rise && tx_bits != 5'h00 && !RES_VALID && !dout_pend
      |=> DOUT == $past(tx[RES_W-1]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("data bit out of order");

  property p_shared_high;
    shared_mode && active && sclk_rise && tx_bits == 5'h00 && !RES_VALID && !dout_pend
      |=> DOUT;
  endproperty
  a_shared_high: assert property (p_shared_high) else $error("shared pin not high");

  property p_shared_fall;
    RES_VALID && shared_mode && DOUT |=> !DOUT;
  endproperty
  a_shared_fall: assert property (p_shared_fall) else $error("shared pin did not fall");

  property p_sleep_block;
    byte_done && state == ST_CMD && sleeping && !sleep_ok(rx_byte) |=> state == ST_CMD;
  endproperty
  a_sleep_block: assert property (p_sleep_block) else $error("command taken in sleep");

  property p_read_last;
    cmd_load_res |=> tx == $past(result_buf) && tx_bits == RES_BITS;
  endproperty
  a_read_last: assert property (p_read_last) else $error("read gave wrong result");

  property p_timeout;
    to_hit |=> bit_cnt == 3'h0 && state == ST_CMD;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout left partial command");

  property p_saturate;
    RES_VALID && RES_RAW > RAW_POS_LIM |=> result_buf == RES_MAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("result not saturated");

endmodule

/* File: verif/adcsp_host_model.sv */
`timescale 1ns/100ps
module adcsp_host_model
  import adcsp_pkg::*;
(
  // System
  input wire logic clk,
  // Serial pins toward the port
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  // Phases of a 125 ns link clock on a 5 ns system clock, far above the 3 CLK minimum
  localparam int HALF_HI = 12;
  localparam int HALF_LO = 13;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Select or release; the gap lets the port's synchronisers settle
  task automatic select(input logic on);
    cs_n <= ~on;
    wait_clk(6);
  endtask

  // Launch on the rise, sample the port's output at the fall; clock idles low
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk <= 1'b1;
      din <= tx[i];
      wait_clk(HALF_HI);
      sclk <= 1'b0;
      rx[i] = dout;
      wait_clk(HALF_LO);
    end
  endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import adcsp_pkg::*;
  typedef struct packed {
    logic [RAW_W-1:0] raw;
    logic [RES_W-1:0] res;
  } adcsp_row_t;
  localparam int TO_CYC = 64;
  localparam adcsp_row_t ROWS [5] = '{'{26'h0000123, 24'h000123}, '{26'h1000000, 24'h7fffff},
    '{26'h3000000, 24'h800000}, '{26'h07fffff, 24'h7fffff}, '{26'h3ffffff, 24'hffffff}};

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b1;
  logic sleep = 1'b0;
  logic ext_osc = 1'b1;
  logic res_valid = 1'b0;
  logic signed [RAW_W-1:0] res_raw = '0;
  logic cs_n, sclk, din, dout, dout_oe, conv_ready_n, wake_req;
  int err_total = 0;
  int total_checks = 0;
  int wake_cnt = 0;
  int hi;
  logic [7:0] rx;
  logic [23:0] got;

  always #2.5 clk = ~clk;

  adcsp_serial_port #(.TIMEOUT_CYCLES(TO_CYC)) i_dut (.CLK(clk), .RST(rst), .CS_N(cs_n),
    .SCLK(sclk), .DIN(din), .DOUT(dout), .DOUT_OE(dout_oe), .CONV_READY_N(conv_ready_n),
    .START(start), .SLEEP(sleep), .EXT_OSC(ext_osc), .RES_VALID(res_valid),
    .RES_RAW(res_raw), .WAKE_REQ(wake_req));
  adcsp_host_model i_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe));

  always @(posedge clk) if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;

  task automatic chk_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_word(input logic [23:0] g, input logic [23:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // New result from the core while the serial clock is low; counts cycles the pin is high
  task automatic pulse(input logic [RAW_W-1:0] raw, input logic on_dout, output int h);
    h = 0;
    res_raw <= raw;
    res_valid <= 1'b1;
    @(posedge clk);
    res_valid <= 1'b0;
    repeat (10) begin
      #1;
      if ((on_dout ? dout : conv_ready_n) === 1'b1) h++;
      @(posedge clk);
    end
  endtask

  // Clocks out a result while sending no-op bytes
  task automatic read_word(output logic [23:0] w);
    logic [7:0] b;
    w = '0;
    for (int k = 0; k < 3; k++) begin
      i_host.xfer(CMD_NOP, 8, b);
      w = {w[15:0], b};
    end
  endtask

  task automatic register_read_cmd(input logic [3:0] a, output logic [7:0] v);
    i_host.xfer({CMD_REGISTER_READ_CMD_HI, a}, 8, v);
    i_host.xfer(8'h00, 8, v);
    i_host.xfer(CMD_NOP, 8, v);
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    logic [7:0] b;
    i_host.xfer({CMD_WREG_HI, a}, 8, b);
    i_host.xfer(8'h00, 8, b);
    i_host.xfer(v, 8, b);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    i_host.select(1'b1);
    chk_bit(dout_oe, 1'b1);
    register_read_cmd(4'h0, rx);
    chk_word({16'h0, rx}, 24'h000001);
    register_read_cmd(4'ha, rx);
    chk_word({16'h0, rx}, 24'h000050);
    wreg(4'h2, 8'hff);
    ext_osc <= 1'b0;
    register_read_cmd(4'h2, rx);
    chk_word({16'h0, rx}, 24'h00007f);
    $display("test registers done");
    foreach (ROWS[r]) begin
      pulse(ROWS[r].raw, 1'b0, hi);
      chk_bit(conv_ready_n, 1'b0);
      i_host.xfer(CMD_READ, 8, rx);
      chk_bit(conv_ready_n, 1'b1);
      read_word(got);
      chk_word(got, ROWS[r].res);
    end
    $display("test result rows done");
    i_host.select(1'b0);
    chk_bit(dout_oe, 1'b0);
    pulse(26'h0000011, 1'b0, hi);
    chk_bit(conv_ready_n, 1'b0);
    pulse(26'h0000022, 1'b0, hi);
    chk_word(24'(hi), 24'(PULSE_CYC));
    chk_bit(conv_ready_n, 1'b0);
    $display("test ready pulse done");
    i_host.select(1'b1);
    wreg(4'ha, 8'h08);
    pulse(26'h00000a5, 1'b1, hi);
    chk_bit(dout, 1'b0);
    chk_bit(conv_ready_n, 1'b0);
    i_host.xfer(CMD_READ, 8, rx);
    read_word(got);
    chk_word(got, 24'h0000a5);
    i_host.xfer(CMD_NOP, 8, rx);
    chk_word({16'h0, rx}, 24'h0000ff);
    pulse(26'h00000b6, 1'b1, hi);
    pulse(26'h00000c7, 1'b1, hi);
    chk_word(24'(hi), 24'(PULSE_CYC));
    chk_bit(dout, 1'b0);
    wreg(4'ha, 8'h00);
    $display("test shared pin done");
    sleep <= 1'b1;
    hi = wake_cnt;
    // Dropped write leaves its zero count byte to be taken as a wake command
    wreg(4'h1, 8'h55);
    chk_word(24'(wake_cnt - hi), 24'h000001);
    repeat (2) begin
      i_host.xfer(CMD_READ, 8, rx);
      read_word(got);
      chk_word(got, 24'h0000c7);
    end
    sleep <= 1'b0;
    start <= 1'b0;
    hi = wake_cnt;
    // Start pin low filters commands the same way as sleep
    wreg(4'h1, 8'h66);
    chk_word(24'(wake_cnt - hi), 24'h000001);
    start <= 1'b1;
    register_read_cmd(4'h1, rx);
    chk_word({16'h0, rx}, 24'h000000);
    $display("test sleep done");
    i_host.xfer(8'h20, 4, rx);
    repeat (TO_CYC + 10) @(posedge clk);
    register_read_cmd(4'h0, rx);
    chk_word({16'h0, rx}, 24'h000001);
    $display("test timeout done");
    wreg(4'h4, 8'h3c);
    i_host.select(1'b0);
    i_host.select(1'b1);
    register_read_cmd(4'h4, rx);
    chk_word({16'h0, rx}, 24'h00003c);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    i_host.wait_clk(6);
    register_read_cmd(4'h4, rx);
    chk_word({16'h0, rx}, 24'h000000);
    $display("test reset done");
    tally_and_finish();
  end

  // Bound on the whole run; a hang counts as a mismatch
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    $display("mismatch at %0t got %h exp %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule
